// >>> ofd_pkg.sv
// Purpose: Shared constants and types of the operand field decoder.
// Assumes: Included before every other file of the block.
// Notes: Register offsets are byte addresses on the Wishbone slave.
package ofd_pkg;
  // ********************************
  // Field codes
  // ********************************
  localparam logic [2:0] IDX_NONE = 3'h4;
  localparam logic [1:0] SS_X1 = 2'h0;
  typedef enum logic [2:0] {
    GPR_EAX = 3'h0, GPR_ECX = 3'h1, GPR_EDX = 3'h2, GPR_EBX = 3'h3,
    GPR_NONE = 3'h4, GPR_EBP = 3'h5, GPR_ESI = 3'h6, GPR_EDI = 3'h7
  } ofd_gpr_t;
  typedef enum logic [2:0] {
    SEG_ES = 3'h0, SEG_CS = 3'h1, SEG_SS = 3'h2, SEG_DS = 3'h3,
    SEG_FS = 3'h4, SEG_GS = 3'h5, SEG_BAD = 3'h7
  } ofd_seg_t;
  typedef enum logic [1:0] {
    CLS_NONE = 2'h0, CLS_CTRL = 2'h1, CLS_DBG = 2'h2, CLS_TEST = 2'h3
  } ofd_cls_t;
  typedef enum logic [1:0] {
    FA_KEEP = 2'h0, FA_MOD = 2'h1, FA_CLR = 2'h2, FA_SET = 2'h3
  } ofd_fact_t;
  // ********************************
  // Flag positions
  // ********************************
  localparam int FLG_CF = 0;
  localparam int FLG_PF = 1;
  localparam int FLG_AF = 2;
  localparam int FLG_ZF = 3;
  localparam int FLG_SF = 4;
  localparam int FLG_TF = 5;
  localparam int FLG_IF = 6;
  localparam int FLG_DF = 7;
  localparam int FLG_OF = 8;
  localparam int NUM_FLAGS = 9;
  localparam logic [8:0] FLAGS_RST = 9'h000;
  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] ADR_CLK_BASE = 8'h00;
  localparam logic [7:0] ADR_CLK_ALT = 8'h04;
  localparam logic [7:0] ADR_CLK_VAR = 8'h08;
  localparam logic [7:0] ADR_FLAGS = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_CC_REAL = 8'h14;
  localparam logic [7:0] ADR_CC_PROT = 8'h18;
  localparam logic [31:0] CLK_TBL_RST = 32'h00000000;
  localparam logic [15:0] CLK_VAR_RST = 16'h0000;
  localparam int ST_SPEC_INV = 0;
  localparam int ST_SEG3_INV = 1;
  localparam int ST_EA_UNDEF = 2;
  localparam int ST_IDX_NONE = 3;
  // ********************************
  // Clock count adders
  // ********************************
  localparam logic [15:0] EA_TWO_REG_ADD = 16'h0001;
  localparam logic [15:0] PEN_EVEN_ONE = 16'h0002;
  localparam logic [15:0] PEN_EVEN_BOTH = 16'h0004;
  localparam logic [15:0] PEN_ODD_ONE = 16'h0004;
  localparam logic [15:0] PEN_ODD_BOTH = 16'h0008;
endpackage : ofd_pkg

// >>> ofd_cc_if.sv
// Purpose: Carries clock count inputs and results to the calculator.
// Assumes: Columns 0..3 are real hit, real miss, prot hit, prot miss.
// Notes: Used only between the top and its calculator.
`timescale 1ns/1ns
interface ofd_cc_if;
  logic [3:0][7:0] base;
  logic [3:0][7:0] alt;
  logic use_alt;
  logic [7:0] per_iter;
  logic [7:0] per_level;
  logic [7:0] rep_n;
  logic [4:0] level;
  logic two_reg;
  logic size32;
  logic odd_addr;
  logic mis16;
  logic rd;
  logic wr;
  logic [3:0][15:0] cc;
  modport calc (input base, alt, use_alt, per_iter, per_level, rep_n, level,
    two_reg, size32, odd_addr, mis16, rd, wr, output cc);
  modport ctrl (output base, alt, use_alt, per_iter, per_level, rep_n, level,
    two_reg, size32, odd_addr, mis16, rd, wr, input cc);
endinterface : ofd_cc_if

// >>> ofd_clk_calc.sv
// Purpose: Combinational clock count for all four mode and cache columns.
// Assumes: Base values already exclude wait states, holds and exceptions.
// Notes: Alignment adders go to the cache miss columns only.
`timescale 1ns/1ns
module ofd_clk_calc
  import ofd_pkg::*;
(
  ofd_cc_if.calc cc_if // Count inputs and results
);
  // ********************************
  // Alignment penalty
  // ********************************
  function automatic logic [15:0] align_pen(input logic size32,
    input logic odd, input logic mis16, input logic rd, input logic wr);
    logic [15:0] p;
    p = 16'h0000;
    if (size32 && odd) begin
      if (rd && wr) p = PEN_ODD_BOTH;
      else if (rd || wr) p = PEN_ODD_ONE;
    end else if (size32 || mis16) begin
      if (rd && wr) p = PEN_EVEN_BOTH;
      else if (rd || wr) p = PEN_EVEN_ONE;
    end
    return p;
  endfunction : align_pen

  logic [15:0] var_add;
  logic [15:0] ea_add;
  logic [15:0] pen;

  always_comb begin
    var_add = 16'(16'(cc_if.per_iter) * 16'(cc_if.rep_n))
      + 16'(16'(cc_if.per_level) * 16'(cc_if.level));
    ea_add = cc_if.two_reg ? EA_TWO_REG_ADD : 16'h0000;
    // Aligned 16-bit operands cost nothing extra on a miss
    pen = align_pen(cc_if.size32, cc_if.odd_addr, cc_if.mis16,
      cc_if.rd, cc_if.wr);
    for (int c = 0; c < 4; c++) begin
      // base figures assume zero waits, no hold, no fault
      cc_if.cc[c] = 16'(cc_if.use_alt ? cc_if.alt[c] : cc_if.base[c])
        + var_add + ea_add + ((c % 2 == 1) ? pen : 16'h0000);
    end
  end
endmodule : ofd_clk_calc

// >>> ofd_decoder.sv
// Purpose: Decodes operand register fields, flag actions and clock counts.
// Assumes: Front end holds fields stable while presenting them.
// Notes: Register selects are combinational; counts are registered.
//
// Notes on behaviour
// - Index field selects register; 100 means none.
// - Scale field gives multiplier one, two, four, eight.
// - Two-bit segment field maps ES, CS, SS, DS.
// - Three-bit segment adds FS, GS; 110/111 undefined.
// - Special selector maps control, debug, test registers.
// - Unlisted class and selector pairs are invalid.
// - Nine status and control flags are tracked.
// - Each flag is modified, kept, cleared or set.
// - Base counts assume no waits, holds, exceptions.
// - Two register address components add one clock.
// - Miss counts assume aligned 16-bit operands.
// - Misaligned 16 or even 32 adds 2/4.
// - Odd 32-bit operand adds 4, or 8.
// - Counts reported per mode and hit/miss.
// - Variable counts use repeats, level, alternatives.
`timescale 1ns/1ns
module ofd_decoder
  import ofd_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic fld_valid, // Fields presented
  input wire logic [2:0] index_field, // Index field
  input wire logic [1:0] scale_field, // Scale field
  input wire logic [1:0] seg_select_two_bit, // Two-bit segment field
  input wire logic [2:0] seg_select_three_bit, // Three-bit segment field
  input wire logic [2:0] spec_sel_field, // Special register field
  input wire logic [1:0] spec_class, // Special register class
  output ofd_gpr_t index_reg, // Index register, NONE if absent
  output logic index_used, // Index register present
  output logic [3:0] scale_mult, // One, two, four or eight
  output logic ea_undefined, // Scale nonzero without index
  output ofd_seg_t seg_two, // Segment from two-bit field
  output ofd_seg_t seg_three, // Segment from three-bit field
  output logic seg_three_invalid, // Three-bit code undefined
  output logic [2:0] spec_reg_num, // Special register number
  output logic spec_invalid, // Bad class and selector pair
  input wire logic flag_apply, // Apply flag actions this cycle
  input wire logic [17:0] flag_action, // Two bits per flag
  input wire logic [8:0] flag_result, // Flag values from result
  output logic [8:0] flags, // Current flags
  input wire logic cc_req, // Compute clock counts
  input wire logic cc_use_alt, // Memory, not taken or high privilege
  input wire logic [7:0] cc_rep_n, // Repetition count
  input wire logic [4:0] cc_level, // Stack frame level
  input wire logic cc_two_reg, // Two register address parts
  input wire logic cc_size32, // 32-bit operand
  input wire logic cc_odd_addr, // Operand at odd address
  input wire logic cc_mis16, // Misaligned 16-bit operand
  input wire logic cc_rd, // Instruction reads operand
  input wire logic cc_wr, // Instruction writes operand
  output logic [15:0] cc_real_hit, // Real mode, reg or hit
  output logic [15:0] cc_real_miss, // Real mode, miss
  output logic [15:0] cc_prot_hit, // Protected mode, reg or hit
  output logic [15:0] cc_prot_miss, // Protected mode, miss
  output logic cc_valid // Counts updated last cycle
);
  // ********************************
  // Declarations
  // ********************************
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  logic [31:0] clk_base_r;
  logic [31:0] clk_alt_r;
  logic [15:0] clk_var_r;
  logic [8:0] flags_r;
  logic [8:0] flags_nxt;
  logic [3:0] status_r;
  logic [3:0][15:0] cc_r;
  logic cc_valid_r;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_data;
  ofd_cc_if cc_if ();

  // Merges a write under byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
    input logic [31:0] wdat, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = wdat[b*8 +: 8];
    end
    return r;
  endfunction : lane_merge

  // ********************************
  // Index and scale decode
  // ********************************
  always_comb begin
    unique case (index_field)
      3'h0: index_reg = GPR_EAX;
      3'h1: index_reg = GPR_ECX;
      3'h2: index_reg = GPR_EDX;
      3'h3: index_reg = GPR_EBX;
      3'h4: index_reg = GPR_NONE;
      3'h5: index_reg = GPR_EBP;
      3'h6: index_reg = GPR_ESI;
      3'h7: index_reg = GPR_EDI;
    endcase
    index_used = (index_field != IDX_NONE);
    unique case (scale_field)
      2'h0: scale_mult = 4'h1;
      2'h1: scale_mult = 4'h2;
      2'h2: scale_mult = 4'h4;
      2'h3: scale_mult = 4'h8;
    endcase
    // Flags a supplier slip; the address itself is left as decoded
    ea_undefined = !index_used && (scale_field != SS_X1);
  end

  // ********************************
  // Segment decode
  // ********************************
  always_comb begin
    unique case (seg_select_two_bit)
      2'h0: seg_two = SEG_ES;
      2'h1: seg_two = SEG_CS;
      2'h2: seg_two = SEG_SS;
      2'h3: seg_two = SEG_DS;
    endcase
    seg_three_invalid = 1'b0;
    unique case (seg_select_three_bit)
      3'h0: seg_three = SEG_ES;
      3'h1: seg_three = SEG_CS;
      3'h2: seg_three = SEG_SS;
      3'h3: seg_three = SEG_DS;
      3'h4: seg_three = SEG_FS;
      3'h5: seg_three = SEG_GS;
      default: begin
        seg_three = SEG_BAD;
        seg_three_invalid = 1'b1;
      end
    endcase
  end

  // ********************************
  // Special register decode
  // ********************************
  always_comb begin
    spec_invalid = 1'b1;
    unique case (ofd_cls_t'(spec_class))
      CLS_CTRL: begin
        spec_invalid = !(spec_sel_field inside {3'h0, 3'h2, 3'h3});
      end
      CLS_DBG: begin
        spec_invalid = (spec_sel_field inside {3'h4, 3'h5});
      end
      CLS_TEST: begin
        spec_invalid = (spec_sel_field < 3'h3);
      end
      CLS_NONE: begin
        spec_invalid = 1'b1;
      end
    endcase
    // Number is zero on a bad pair so no stray register is named
    spec_reg_num = spec_invalid ? 3'h0 : spec_sel_field;
  end

  // ********************************
  // Flags
  // ********************************
  always_comb begin
    flags_nxt = flags_r;
    if (bus_wr && wb_adr_i == ADR_FLAGS) begin
      flags_nxt = 9'(lane_merge({23'h0, flags_r}, wb_dat_i, wb_sel_i));
    end
    // Instruction actions win over a software write in the same cycle
    if (flag_apply) begin
      for (int i = 0; i < NUM_FLAGS; i++) begin
        unique case (ofd_fact_t'(flag_action[i*2 +: 2]))
          FA_KEEP: flags_nxt[i] = flags_nxt[i];
          FA_MOD: flags_nxt[i] = flag_result[i];
          FA_CLR: flags_nxt[i] = 1'b0;
          FA_SET: flags_nxt[i] = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

  // ********************************
  // Decode status capture
  // ********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= 4'h0;
    end else if (fld_valid) begin
      status_r[ST_SPEC_INV] <= spec_invalid;
      status_r[ST_SEG3_INV] <= seg_three_invalid;
      status_r[ST_EA_UNDEF] <= ea_undefined;
      status_r[ST_IDX_NONE] <= !index_used;
    end
  end

  // ********************************
  // Clock counts
  // ********************************
  always_comb begin
    cc_if.base = clk_base_r;
    cc_if.alt = clk_alt_r;
    cc_if.use_alt = cc_use_alt;
    cc_if.per_iter = clk_var_r[7:0];
    cc_if.per_level = clk_var_r[15:8];
    cc_if.rep_n = cc_rep_n;
    cc_if.level = cc_level;
    cc_if.two_reg = cc_two_reg;
    cc_if.size32 = cc_size32;
    cc_if.odd_addr = cc_odd_addr;
    cc_if.mis16 = cc_mis16;
    cc_if.rd = cc_rd;
    cc_if.wr = cc_wr;
  end

  ofd_clk_calc u_calc (
    .cc_if (cc_if.calc)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cc_r <= '0;
      cc_valid_r <= 1'b0;
    end else begin
      cc_valid_r <= cc_req;
      if (cc_req) cc_r <= cc_if.cc;
    end
  end

  assign cc_real_hit = cc_r[0];
  assign cc_real_miss = cc_r[1];
  assign cc_prot_hit = cc_r[2];
  assign cc_prot_miss = cc_r[3];
  assign cc_valid = cc_valid_r;

  // ********************************
  // Wishbone slave
  // ********************************
  // One wait state: ack one edge after the request, dropped next cycle
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_r;
  assign bus_wr = bus_req && wb_we_i;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_base_r <= CLK_TBL_RST;
      clk_alt_r <= CLK_TBL_RST;
      clk_var_r <= CLK_VAR_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == ADR_CLK_BASE) begin
        clk_base_r <= lane_merge(clk_base_r, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == ADR_CLK_ALT) begin
        clk_alt_r <= lane_merge(clk_alt_r, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == ADR_CLK_VAR) begin
        clk_var_r <= 16'(lane_merge({16'h0, clk_var_r}, wb_dat_i, wb_sel_i));
      end
    end
  end

  always_comb begin
    unique case (wb_adr_i)
      ADR_CLK_BASE: rd_data = clk_base_r;
      ADR_CLK_ALT: rd_data = clk_alt_r;
      ADR_CLK_VAR: rd_data = {16'h0, clk_var_r};
      ADR_FLAGS: rd_data = {23'h0, flags_r};
      ADR_STATUS: rd_data = {28'h0, status_r};
      ADR_CC_REAL: rd_data = {cc_r[1], cc_r[0]};
      ADR_CC_PROT: rd_data = {cc_r[3], cc_r[2]};
      // Unmapped addresses still ack, reading zero
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack_r <= bus_req;
      if (bus_req && !wb_we_i) wb_dat_r <= rd_data;
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
endmodule : ofd_decoder

// >>> ofd_decoder_properties.sv
// Purpose: Concurrent checks on the decoder top ports.
// Assumes: Bound to ofd_decoder from the bench.
// Notes: Field relations are combinational but sampled on clk.
`timescale 1ns/1ns
module ofd_decoder_properties
  import ofd_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [2:0] index_field, // Field
  input wire logic [1:0] scale_field, // Field
  input wire logic [1:0] seg_select_two_bit, // Field
  input wire logic [2:0] seg_select_three_bit, // Field
  input wire logic [2:0] spec_sel_field, // Field
  input wire logic [1:0] spec_class, // Field
  input wire ofd_gpr_t index_reg, // Decode
  input wire logic index_used, // Decode
  input wire logic [3:0] scale_mult, // Decode
  input wire logic ea_undefined, // Decode
  input wire ofd_seg_t seg_two, // Decode
  input wire ofd_seg_t seg_three, // Decode
  input wire logic seg_three_invalid, // Decode
  input wire logic [2:0] spec_reg_num, // Decode
  input wire logic spec_invalid, // Decode
  input wire logic flag_apply, // Flags
  input wire logic [17:0] flag_action, // Flags
  input wire logic [8:0] flag_result, // Flags
  input wire logic [8:0] flags, // Flags
  input wire logic cc_req, // Counts
  input wire logic cc_valid // Counts
);
  // ********************************
  // Checks
  // ********************************
  localparam logic [31:0] SPEC_OK = 32'hF8CF0D00;
  logic [8:0] fmask;
  logic [8:0] fval;
  always_comb begin
    for (int i = 0; i < NUM_FLAGS; i++) begin
      fmask[i] = flag_action[2*i+:2] != FA_KEEP;
      fval[i] = (flag_action[2*i+:2] == FA_MOD) ? flag_result[i] : flag_action[2*i];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  idx_map_a: assert property (index_reg == index_field &&
    index_used == (index_field != IDX_NONE))
    else $error("index select mismatch");
  scale_mult_a: assert property (scale_mult == (4'h1 << scale_field))
    else $error("scale multiplier mismatch");
  ea_undef_a: assert property (ea_undefined ==
    (index_field == IDX_NONE && scale_field != SS_X1))
    else $error("undefined address flag mismatch");
  seg_two_a: assert property (seg_two == {1'h0, seg_select_two_bit})
    else $error("two bit segment mismatch");
  seg_three_a: assert property (
    seg_three_invalid == (seg_select_three_bit[2:1] == 2'h3) &&
    seg_three == (seg_three_invalid ? 3'h7 : seg_select_three_bit))
    else $error("three bit segment mismatch");
  spec_sel_a: assert property (
    spec_invalid == !SPEC_OK[{spec_class, spec_sel_field}] &&
    spec_reg_num == (spec_invalid ? 3'h0 : spec_sel_field))
    else $error("special selector mismatch");
  flag_upd_a: assert property (flag_apply |=>
    (flags & $past(fmask)) == ($past(fval) & $past(fmask)))
    else $error("flag action not applied");
  cc_valid_a: assert property (cc_req |=> cc_valid ##1 (cc_valid == $past(cc_req)))
    else $error("count valid pulse wrong");
endmodule : ofd_decoder_properties

// >>> ofd_front_model.sv
// Purpose: Front end model presenting instruction fields to the decoder.
// Assumes: One presentation requested at a time.
// Notes: Idle fields toggle so stale values never pass for live ones.
`timescale 1ns/1ns
module ofd_front_model
  import ofd_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic pres, // Present want next cycle
  input wire logic allow_bad, // Permit scale without index
  input wire logic [14:0] want, // {cls,sel,seg3,seg2,scale,index}
  output logic fld_valid, // Fields live
  output logic [2:0] index_field, // Index
  output logic [1:0] scale_field, // Scale
  output logic [1:0] seg2, // Two-bit segment
  output logic [2:0] seg3, // Three-bit segment
  output logic [2:0] spec_sel, // Selector
  output logic [1:0] spec_cls // Class
);
  // ********************************
  // Field register
  // ********************************
  logic [14:0] f_r;
  assign {spec_cls, spec_sel, seg3, seg2, scale_field, index_field} = f_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f_r <= 15'h0000;
      fld_valid <= 1'h0;
    end else if (pres) begin
      // Only a scenario asking for a bad encoding gets one
      f_r <= (want[2:0] == IDX_NONE && !allow_bad) ?
        {want[14:5], SS_X1, want[2:0]} : want;
      fld_valid <= 1'h1;
    end else begin
      f_r <= ~f_r;
      fld_valid <= 1'h0;
    end
  end
endmodule : ofd_front_model

// >>> ofd_decoder_tb.sv
// Purpose: Self-checking bench for the operand field decoder.
// Assumes: Wishbone answers within twenty cycles.
// Notes: Expectations come from bench functions, never from the design.
`timescale 1ns/1ns
module ofd_decoder_tb
  import ofd_pkg::*;
;
  // ********************************
  // Signals
  // ********************************
  localparam logic [31:0] SPEC_OK = 32'hF8CF0D00;
  logic clk = 1'h0, rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, wd, bb, ab;
  logic wb_ack_o, fld_valid, index_used, ea_undefined, seg_three_invalid, spec_invalid, cc_valid;
  logic pres = 1'h0, bad = 1'h0, flag_apply = 1'h0, cc_req = 1'h0, cc_use_alt = 1'h0;
  logic cc_two_reg = 1'h0, cc_size32 = 1'h0, cc_odd_addr = 1'h0;
  logic cc_mis16 = 1'h0, cc_rd = 1'h0, cc_wr = 1'h0;
  logic [14:0] want = 15'h0000;
  logic [2:0] index_field, seg_select_three_bit, spec_sel_field, spec_reg_num;
  logic [1:0] scale_field, seg_select_two_bit, spec_class;
  logic [3:0] scale_mult;
  ofd_gpr_t index_reg;
  ofd_seg_t seg_two, seg_three;
  logic [17:0] flag_action = 18'h00000;
  logic [8:0] flag_result = 9'h000, flags, fm;
  logic [7:0] cc_rep_n = 8'h00;
  logic [4:0] cc_level = 5'h00;
  logic [15:0] cc_real_hit, cc_real_miss, cc_prot_hit, cc_prot_miss, pv;
  int seed = 81, fail_count = 0, check_count = 0, n = 0;
  always #25 clk = ~clk;
  ofd_decoder dut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .fld_valid, .index_field, .scale_field, .seg_select_two_bit,
    .seg_select_three_bit, .spec_sel_field, .spec_class, .index_reg, .index_used, .scale_mult,
    .ea_undefined, .seg_two, .seg_three, .seg_three_invalid, .spec_reg_num, .spec_invalid,
    .flag_apply, .flag_action, .flag_result, .flags, .cc_req, .cc_use_alt, .cc_rep_n, .cc_level,
    .cc_two_reg, .cc_size32, .cc_odd_addr, .cc_mis16, .cc_rd, .cc_wr, .cc_real_hit,
    .cc_real_miss, .cc_prot_hit, .cc_prot_miss, .cc_valid);
  ofd_front_model front (.clk, .rst, .pres, .allow_bad(bad), .want, .fld_valid, .index_field,
    .scale_field, .seg2(seg_select_two_bit), .seg3(seg_select_three_bit),
    .spec_sel(spec_sel_field), .spec_cls(spec_class));
  // ********************************
  // Tasks and models
  // ********************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (wb_ack_o !== 1'h1) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : wb
  task automatic present(input logic [14:0] w, input logic b);
    @(posedge clk);
    pres <= 1'h1;
    want <= w;
    bad <= b;
    @(posedge clk);
    pres <= 1'h0;
    @(negedge clk);
  endtask : present
  function automatic logic [8:0] nf(input logic [8:0] f, input logic [17:0] a, input logic [8:0] r);
    for (int i = 0; i < 9; i++) begin
      if (a[2*i+:2] != 2'h0) f[i] = (a[2*i+:2] == 2'h1) ? r[i] : a[2*i];
    end
    return f;
  endfunction : nf
  function automatic logic [15:0] ecc(input int c);
    logic [15:0] s;
    logic [15:0] p;
    s = {8'h00, cc_use_alt ? ab[8*c+:8] : bb[8*c+:8]} + pv[7:0] * cc_rep_n;
    s = s + pv[15:8] * cc_level + {15'h0000, cc_two_reg};
    p = 16'h0000;
    if (cc_size32 && cc_odd_addr) begin
      p = (cc_rd && cc_wr) ? 16'h0008 : (cc_rd || cc_wr) ? 16'h0004 : p;
    end else if (cc_size32 || cc_mis16) begin
      p = (cc_rd && cc_wr) ? 16'h0004 : (cc_rd || cc_wr) ? 16'h0002 : p;
    end
    // Alignment penalty lands only on cache miss columns
    return (c % 2 == 1) ? s + p : s;
  endfunction : ecc
  // ********************************
  // Sequence
  // ********************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    for (int a = 0; a <= 8'h1C; a += 4) begin
      wb(1'h0, a[7:0], 32'h0, 4'hF);
      chk("reset value", 32'h0, q);
    end
    $display("test registers done");
    for (int i = 0; i < 32; i++) begin
      present({i[4:3], i[2:0], i[2:0], i[1:0], i[4:3], i[2:0]}, 1'h1);
      chk("index", {i[2:0] != 3'h4, 4'h1 << i[4:3], i[2:0] == 3'h4 && i[4:3] != 2'h0, i[2:0]},
        {index_used, scale_mult, ea_undefined, index_reg});
      chk("segment", {1'h0, i[1:0], (i[2:1] == 2'h3) ? 3'h7 : i[2:0], i[2:1] == 2'h3},
        {seg_two, seg_three, seg_three_invalid});
      chk("special", {!SPEC_OK[i[4:0]], SPEC_OK[i[4:0]] ? i[2:0] : 3'h0},
        {spec_invalid, spec_reg_num});
    end
    present({2'h0, 3'h0, 3'h6, 2'h0, 2'h1, 3'h4}, 1'h1);
    wb(1'h1, ADR_STATUS, 32'h0, 4'hF);
    wb(1'h0, ADR_STATUS, 32'h0, 4'hF);
    chk("status", 32'h0000000F, q);
    $display("test decode done");
    fm = 9'($random(seed));
    wb(1'h1, ADR_FLAGS, {23'h0, fm}, 4'hF);
    wb(1'h0, ADR_FLAGS, 32'h0, 4'hF);
    chk("flags rw", {23'h0, fm}, q);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      flag_apply <= 1'h1;
      flag_action <= (i == 0) ? 18'h3FFFF : (i == 1) ? 18'h2AAAA : 18'($random(seed));
      flag_result <= 9'($random(seed));
      @(posedge clk);
      flag_apply <= 1'h0;
      fm = nf(fm, flag_action, flag_result);
      @(negedge clk);
      chk("flags", {23'h0, fm}, {23'h0, flags});
    end
    $display("test flags done");
    bb = $random(seed);
    ab = $random(seed);
    pv = 16'($random(seed));
    wd = $random(seed);
    wb(1'h1, ADR_CLK_BASE, bb, 4'hF);
    wb(1'h1, ADR_CLK_ALT, ab, 4'hF);
    wb(1'h1, ADR_CLK_VAR, {16'h0, pv}, 4'hF);
    wb(1'h1, ADR_CLK_VAR, wd, 4'h2);
    pv[15:8] = wd[15:8];
    wb(1'h0, ADR_CLK_VAR, 32'h0, 4'hF);
    chk("lanes", {16'h0, pv}, {16'h0, q[15:0]});
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      cc_req <= 1'h1;
      {cc_size32, cc_odd_addr, cc_mis16, cc_rd, cc_wr} <= i[4:0];
      {cc_use_alt, cc_two_reg, cc_level, cc_rep_n} <= 15'($random(seed));
      @(posedge clk);
      cc_req <= 1'h0;
      @(negedge clk);
      chk("count valid", 32'h1, {31'h0, cc_valid});
      chk("real counts", {ecc(1), ecc(0)},
        {cc_real_miss, cc_real_hit});
      chk("prot counts", {ecc(3), ecc(2)}, {cc_prot_miss, cc_prot_hit});
    end
    wb(1'h0, ADR_CC_PROT, 32'h0, 4'hF);
    chk("count register", {ecc(3), ecc(2)}, q);
    $display("test counts done");
    tally_and_finish();
  end
endmodule : ofd_decoder_tb
bind ofd_decoder ofd_decoder_properties chk_i (.clk, .rst, .index_field, .scale_field,
  .seg_select_two_bit, .seg_select_three_bit, .spec_sel_field, .spec_class, .index_reg,
  .index_used, .scale_mult, .ea_undefined, .seg_two, .seg_three, .seg_three_invalid,
  .spec_reg_num, .spec_invalid, .flag_apply, .flag_action, .flag_result, .flags, .cc_req,
  .cc_valid);
